/* File: common/arc_pkg.sv */
// Purpose: shared constants for the converter control block
// Assumes: 32-bit AHB-Lite register bus, word aligned registers
// Notes:   offsets are byte addresses within the block's window
package arc_pkg;

    localparam int unsigned ADDR_W = 8;

    // register byte offsets
    localparam logic [7:0] OFS_MODE      = 8'h00;
    localparam logic [7:0] OFS_CHSEL     = 8'h04;
    localparam logic [7:0] OFS_PORTCFG   = 8'h08;
    localparam logic [7:0] OFS_RESULT10  = 8'h0c;
    localparam logic [7:0] OFS_RESULT8   = 8'h10;
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h14;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h18;
    localparam logic [7:0] OFS_IRQ_EN    = 8'h1c;

    // converter_mode_reg fields, channel and port config widths
    localparam int unsigned MODE_START_BIT  = 7;
    localparam int unsigned MODE_ENABLE_BIT = 0;
    localparam int unsigned MODE_TIME_LSB   = 1;
    localparam int unsigned MODE_TIME_MSB   = 5;
    localparam int unsigned CHSEL_W         = 3;
    localparam int unsigned PORTCFG_W       = 4;

    // values after reset
    localparam logic [7:0]  MODE_RST     = 8'h00;
    localparam logic [2:0]  CHSEL_RST    = 3'h0;
    localparam logic [3:0]  PORTCFG_RST  = 4'h0;
    localparam logic [15:0] RESULT10_RST = 16'h0000;
    localparam logic [7:0]  RESULT8_RST  = 8'h00;
    localparam logic [0:0]  IRQ_EN_RST   = 1'h0;

    // conversion sequencing
    localparam int unsigned SAR_BITS       = 10;
    localparam int unsigned RESULT10_SHIFT = 6;
    localparam logic [3:0]  SAMPLE_STEPS   = 4'h2;
    localparam logic [9:0]  SAR_MSB_SET    = 10'h200;
    localparam int unsigned IRQ_CONV_END   = 0;

    typedef enum logic [1:0] {
        ARC_IDLE    = 2'b00,
        ARC_SAMPLE  = 2'b01,
        ARC_CONVERT = 2'b11
    } arc_state_t;

    // registers whose write cancels a finishing conversion
    function automatic logic is_cfg_reg(input logic [7:0] ofs);
        return (ofs == OFS_MODE) || (ofs == OFS_CHSEL) ||
               (ofs == OFS_PORTCFG);
    endfunction : is_cfg_reg

    function automatic logic is_result_reg(input logic [7:0] ofs);
        return (ofs == OFS_RESULT10) || (ofs == OFS_RESULT8);
    endfunction : is_result_reg

endpackage : arc_pkg

/* File: verilog/arc_sar_seq.sv */
// Purpose: sample and successive approximation sequencer
// Assumes: comparator output is synchronous to core_clk
// Notes:   conversion time covers sampling plus ten compare steps
module arc_sar_seq (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        run,
    input  wire logic        restart,
    input  wire logic        hold,
    input  wire logic [4:0]  step_len,
    input  wire logic        cmp_in,
    output logic [9:0]       dac_code,
    output logic             sample_on,
    output logic             busy,
    output logic             done,
    output logic [9:0]       result
);

    arc_pkg::arc_state_t state_q, state_d;
    logic [4:0] cyc_q,  cyc_d;
    logic [3:0] step_q, step_d;
    logic [9:0] sar_q,  sar_d;
    logic [3:0] bit_q,  bit_d;
    logic       done_d;
    logic       step_end;

    assign step_end = (cyc_q == step_len);

    always_comb begin
        state_d = state_q;
        cyc_d   = step_end ? 5'h00 : cyc_q + 5'h01;
        step_d  = step_q;
        sar_d   = sar_q;
        bit_d   = bit_q;
        done_d  = 1'b0;
        if (!run) begin
            state_d = arc_pkg::ARC_IDLE; // abort at once, result kept
            cyc_d   = 5'h00;
        end else if (hold) begin
            cyc_d = cyc_q; // stop mode freezes, even a pending start
        end else if (restart || state_q == arc_pkg::ARC_IDLE) begin
            state_d = arc_pkg::ARC_SAMPLE;
            cyc_d   = 5'h00;
            step_d  = 4'h0;
        end else begin
            case (state_q)
                arc_pkg::ARC_SAMPLE: begin // sampling counts as conversion time
                    if (step_end) begin
                        step_d = step_q + 4'h1;
                        if (step_q + 4'h1 == arc_pkg::SAMPLE_STEPS) begin
                            state_d = arc_pkg::ARC_CONVERT;
                            sar_d   = arc_pkg::SAR_MSB_SET;
                            bit_d   = 4'(arc_pkg::SAR_BITS - 1);
                        end
                    end
                end
                arc_pkg::ARC_CONVERT: begin
                    if (step_end) begin
                        sar_d[bit_q] = cmp_in;
                        if (bit_q == 4'h0) begin
                            done_d  = 1'b1;
                            state_d = arc_pkg::ARC_SAMPLE; // next one at once
                            step_d  = 4'h0;
                        end else begin
                            bit_d        = bit_q - 4'h1;
                            sar_d[bit_d] = 1'b1;
                        end
                    end
                end
                default: state_d = arc_pkg::ARC_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_q <= arc_pkg::ARC_IDLE;
            cyc_q   <= 5'h00;
            step_q  <= 4'h0;
            sar_q   <= 10'h000;
            bit_q   <= 4'h0;
            done    <= 1'b0;
            result  <= 10'h000;
        end else begin
            state_q <= state_d;
            cyc_q   <= cyc_d;
            step_q  <= step_d;
            sar_q   <= sar_d;
            bit_q   <= bit_d;
            done    <= done_d;
            if (done_d) begin
                result <= sar_d;
            end
        end
    end

    assign dac_code  = sar_q;
    assign sample_on = (state_q == arc_pkg::ARC_SAMPLE);
    assign busy      = (state_q != arc_pkg::ARC_IDLE);

endmodule : arc_sar_seq

/* File: verilog/arc_ctrl.sv */
// Purpose: register file, result store and end interrupt of the converter
// Assumes: AHB-Lite single word transfers, zero wait states
// Notes:   result store arbitrates against reads and config writes
//
// Overview of operation
// - result read first, new result stored after
// - config write wins; no store, no interrupt
// - channel rewrite leaves end flag untouched
// - converter halts in stop mode
// - conversion time includes sampling
// - outside stop mode, channel write aborts and restarts conversion
// - clearing start stops, old result kept
// - each end without a config write stores, sets the end flag (interrupt only if enabled), starts next
// - reset clears both result registers
//
// Local design decisions: the register addresses and the AHB-Lite register port.
module arc_ctrl (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // power state and analog side
    input  wire logic        stop_mode,
    input  wire logic        cmp_in,
    output logic [9:0]       dac_code,
    output logic             sample_on,
    output logic [2:0]       analog_channel,
    output logic [3:0]       analog_port_cfg,
    output logic             converter_enable,
    output logic             conv_busy,
    output logic             conv_end_interrupt
);

    logic [7:0]  converter_mode_reg_q,    converter_mode_reg_d;
    logic [2:0]  channel_select_reg_q,    channel_select_reg_d;
    logic [3:0]  analog_port_config_reg_q, analog_port_config_reg_d;
    logic [15:0] result_reg_10bit_q,      result_reg_10bit_d;
    logic [7:0]  result_reg_8bit_q,       result_reg_8bit_d;
    logic        conv_end_irq_flag_q,     conv_end_irq_flag_d;
    logic        irq_en_q,                irq_en_d;
    logic        pend_q,                  pend_d;
    logic [9:0]  pend_val_q,              pend_val_d;
    logic [31:0] hrdata_d;

    // bus phase tracking
    logic        wr_ph_q,   wr_ph_d;
    logic [7:0]  wr_ofs_q,  wr_ofs_d;
    logic        addr_ok;
    logic        rd_req;
    logic [7:0]  a_ofs;

    // sequencer hookup
    logic        run;
    logic        restart;
    logic        seq_done;
    logic [9:0]  seq_result;
    logic        cfg_wr;
    logic        chsel_wr;
    logic        store_now;
    logic [9:0]  store_val;
    logic        result_rd;
    logic        commit;

    assign a_ofs   = haddr[7:0];
    assign addr_ok = hsel && htrans[1] && hready;
    assign rd_req  = addr_ok && !hwrite;

    assign cfg_wr   = wr_ph_q && arc_pkg::is_cfg_reg(wr_ofs_q);
    assign chsel_wr = wr_ph_q && (wr_ofs_q == arc_pkg::OFS_CHSEL);

    // stop mode freezes, start bit alone gates the sequence
    assign run = converter_mode_reg_q[arc_pkg::MODE_START_BIT];
    assign restart = chsel_wr;

    arc_sar_seq u_seq (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .run       (run),
        .restart   (restart),
        .hold      (stop_mode),
        .step_len  (converter_mode_reg_q[arc_pkg::MODE_TIME_MSB:
                                         arc_pkg::MODE_TIME_LSB]),
        .cmp_in    (cmp_in),
        .dac_code  (dac_code),
        .sample_on (sample_on),
        .busy      (conv_busy),
        .done      (seq_done),
        .result    (seq_result)
    );

    // result reads are served from the old value, store follows
    assign result_rd = rd_req && arc_pkg::is_result_reg(a_ofs);
    assign commit    = seq_done && !cfg_wr;

    always_comb begin
        pend_d     = 1'b0;
        pend_val_d = pend_val_q;
        store_now  = 1'b0;
        store_val  = seq_result;
        if (pend_q) begin
            store_now = 1'b1; // deferred store lands after the read
            store_val = pend_val_q;
        end
        if (commit) begin
            if (result_rd) begin
                pend_d     = 1'b1;
                pend_val_d = seq_result;
            end else begin
                store_now = 1'b1;
                store_val = seq_result;
            end
        end
    end

    always_comb begin
        result_reg_10bit_d = result_reg_10bit_q;
        result_reg_8bit_d  = result_reg_8bit_q;
        if (store_now) begin
            result_reg_10bit_d = {store_val, 6'h00};
            result_reg_8bit_d  = store_val[9:2];
        end
    end

    // register writes in the data phase
    always_comb begin
        wr_ph_d  = addr_ok && hwrite;
        wr_ofs_d = addr_ok ? a_ofs : wr_ofs_q;
        converter_mode_reg_d     = converter_mode_reg_q;
        channel_select_reg_d     = channel_select_reg_q;
        analog_port_config_reg_d = analog_port_config_reg_q;
        irq_en_d                 = irq_en_q;
        if (wr_ph_q) begin
            case (wr_ofs_q)
                arc_pkg::OFS_MODE:
                    converter_mode_reg_d = {hwdata[7:6], hwdata[5:0]};
                arc_pkg::OFS_CHSEL:
                    channel_select_reg_d = hwdata[2:0];
                arc_pkg::OFS_PORTCFG:
                    analog_port_config_reg_d = hwdata[3:0];
                arc_pkg::OFS_IRQ_EN:
                    irq_en_d = hwdata[arc_pkg::IRQ_CONV_END];
                default: ;
            endcase
        end
    end

    // sticky end flag; channel writes do not touch it
    always_comb begin
        conv_end_irq_flag_d = conv_end_irq_flag_q;
        if (wr_ph_q && wr_ofs_q == arc_pkg::OFS_IRQ_CLEAR &&
            hwdata[arc_pkg::IRQ_CONV_END]) begin
            conv_end_irq_flag_d = 1'b0;
        end
        // set after clear so a coinciding event is kept
        if (commit) begin
            conv_end_irq_flag_d = 1'b1;
        end
    end

    // read data from flops, sampled in the address phase
    always_comb begin
        hrdata_d = 32'h0000_0000;
        if (rd_req) begin
            case (a_ofs)
                arc_pkg::OFS_MODE:     hrdata_d[7:0] = converter_mode_reg_q;
                arc_pkg::OFS_CHSEL:    hrdata_d[2:0] = channel_select_reg_q;
                arc_pkg::OFS_PORTCFG:
                    hrdata_d[3:0] = analog_port_config_reg_q;
                arc_pkg::OFS_RESULT10: hrdata_d[15:0] = result_reg_10bit_q;
                arc_pkg::OFS_RESULT8:  hrdata_d[7:0] = result_reg_8bit_q;
                arc_pkg::OFS_IRQ_STAT:
                    hrdata_d[arc_pkg::IRQ_CONV_END] = conv_end_irq_flag_q;
                arc_pkg::OFS_IRQ_EN:
                    hrdata_d[arc_pkg::IRQ_CONV_END] = irq_en_q;
                default:               hrdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            converter_mode_reg_q     <= arc_pkg::MODE_RST;
            channel_select_reg_q     <= arc_pkg::CHSEL_RST;
            analog_port_config_reg_q <= arc_pkg::PORTCFG_RST;
            result_reg_10bit_q       <= arc_pkg::RESULT10_RST;
            result_reg_8bit_q        <= arc_pkg::RESULT8_RST;
            conv_end_irq_flag_q      <= 1'b0;
            irq_en_q                 <= arc_pkg::IRQ_EN_RST;
            pend_q                   <= 1'b0;
            pend_val_q               <= 10'h000;
            wr_ph_q                  <= 1'b0;
            wr_ofs_q                 <= 8'h00;
            hrdata                   <= 32'h0000_0000;
        end else begin
            converter_mode_reg_q     <= converter_mode_reg_d;
            channel_select_reg_q     <= channel_select_reg_d;
            analog_port_config_reg_q <= analog_port_config_reg_d;
            result_reg_10bit_q       <= result_reg_10bit_d;
            result_reg_8bit_q        <= result_reg_8bit_d;
            conv_end_irq_flag_q      <= conv_end_irq_flag_d;
            irq_en_q                 <= irq_en_d;
            pend_q                   <= pend_d;
            pend_val_q               <= pend_val_d;
            wr_ph_q                  <= wr_ph_d;
            wr_ofs_q                 <= wr_ofs_d;
            hrdata                   <= hrdata_d;
        end
    end

    // zero wait states; hsize is not checked, only words are issued
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    assign analog_channel     = channel_select_reg_q;
    assign analog_port_cfg    = analog_port_config_reg_q;
    // enable only powers the analog front end; first result may be off
    assign converter_enable   =
        converter_mode_reg_q[arc_pkg::MODE_ENABLE_BIT];
    assign conv_end_interrupt = conv_end_irq_flag_q && irq_en_q;

endmodule : arc_ctrl

/* File: sim/arc_ctrl_asserts.sv */
// Purpose: port level checks for the converter control block
// Assumes: one core_clk domain, zero wait state slave
// Notes:   data phase tracked here to time register writes
module arc_ctrl_asserts (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        stop_mode,
    input wire logic [9:0]  dac_code,
    input wire logic        sample_on,
    input wire logic        conv_busy,
    input wire logic        conv_end_interrupt
);
    logic       dp_wr_q;
    logic [7:0] dp_a_q;
    logic       dp_mode;
    logic       dp_chsel;
    logic       dp_cfg;
    // a write lands at the edge that ends its data phase
    always_ff @(posedge core_clk) begin
        dp_wr_q <= rst_n && hsel && htrans[1] && hready && hwrite;
        dp_a_q  <= haddr[7:0];
    end
    assign dp_mode  = dp_wr_q && (dp_a_q == arc_pkg::OFS_MODE);
    assign dp_chsel = dp_wr_q && (dp_a_q == arc_pkg::OFS_CHSEL);
    assign dp_cfg   = dp_mode || dp_chsel ||
                      (dp_wr_q && (dp_a_q == arc_pkg::OFS_PORTCFG));
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    AST_BUS_OKAY: assert property (hreadyout && !hresp)
        else $error("slave not ready or not okay");
    AST_RESET_CLEAR: assert property (disable iff (1'b0)
        !rst_n |=> hrdata == 32'h0 && !conv_end_interrupt && !sample_on)
        else $error("outputs not cleared by reset");
    AST_CFG_NO_IRQ: assert property (
        dp_cfg |=> !$rose(conv_end_interrupt))
        else $error("end interrupt raised beside config write");
    AST_CHSEL_FLAG: assert property (
        dp_chsel && conv_end_interrupt |=> conv_end_interrupt)
        else $error("channel write dropped the end flag");
    AST_CHSEL_RESTART: assert property (
        dp_chsel && conv_busy && !sample_on |-> ##[1:3] sample_on)
        else $error("channel write did not restart sampling");
    AST_STOP_CLEAR: assert property (
        dp_mode && !hwdata[7] |-> ##[1:2] !conv_busy)
        else $error("clearing start did not stop conversion");
    AST_STOP_FREEZE: assert property (
        stop_mode && $past(stop_mode) && !$past(htrans[1])
        && !$past(htrans[1], 2) |-> $stable(dac_code) && $stable(sample_on))
        else $error("sequencer moved in stop mode");
    AST_END_RUNS: assert property (
        $rose(conv_end_interrupt) && !$past(dp_wr_q) |-> conv_busy)
        else $error("conversion not continued after end");
endmodule : arc_ctrl_asserts

bind arc_ctrl arc_ctrl_asserts i_arc_ctrl_asserts (
    .core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .stop_mode(stop_mode), .dac_code(dac_code), .sample_on(sample_on),
    .conv_busy(conv_busy), .conv_end_interrupt(conv_end_interrupt));

/* File: sim/testbench.sv */
// Purpose: self checking bench for the converter control block
// Assumes: zero wait state bus, comparator modelled from vin
// Notes:   step length 1 gives 24 cycles per conversion
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] RUN  = 32'h83;
    localparam int          CONV = 24;
    logic        core_clk  = 1'b0;
    logic        rst_n     = 1'b0;
    logic        hsel      = 1'b1;
    logic [31:0] haddr     = 32'h0;
    logic [1:0]  htrans    = 2'b00;
    logic        hwrite    = 1'b0;
    logic [31:0] hwdata    = 32'h0;
    logic        stop_mode = 1'b0;
    logic [9:0]  vin       = 10'h0;
    logic        cmp_in;
    logic        hready;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic [9:0]  dac_code;
    logic        sample_on;
    logic [2:0]  ch;
    logic [3:0]  pcfg;
    logic        cen;
    logic        conv_busy;
    logic        irq;
    int          failures   = 0;
    int          n_compared = 0;
    assign hready = hreadyout;
    assign cmp_in = (vin >= dac_code);
    arc_ctrl i_arc_ctrl (
        .core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .stop_mode(stop_mode), .cmp_in(cmp_in),
        .dac_code(dac_code), .sample_on(sample_on), .analog_channel(ch),
        .analog_port_cfg(pcfg), .converter_enable(cen),
        .conv_busy(conv_busy), .conv_end_interrupt(irq));
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask : check
    task automatic tick;
        do @(posedge core_clk); while (hready !== 1'b1);
    endtask : tick
    task automatic put(input logic [7:0] a, input logic w);
        haddr  <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        tick();
    endtask : put
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        put(a, 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        tick();
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        put(a, 1'b0);
        htrans <= 2'b00;
        tick();
        v = hrdata;
    endtask : rd
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd(a, v);
        check(v, exp);
    endtask : rc
    task automatic wait_irq(output int n);
        n = 0;
        #1;
        while (irq !== 1'b1 && n < 4 * CONV) begin
            @(posedge core_clk);
            n++;
        end
    endtask : wait_irq
    task automatic wait_so(input logic lvl);
        while (sample_on !== lvl) @(posedge core_clk);
    endtask : wait_so
    task automatic t_conv(input logic [9:0] v);
        int n;
        vin <= v;
        wr(arc_pkg::OFS_IRQ_CLEAR, 32'h1);
        wait_irq(n);
        wr(arc_pkg::OFS_IRQ_CLEAR, 32'h1);
        wait_irq(n);
        check(n <= CONV + 2, 1'b1);
        rc(arc_pkg::OFS_RESULT10, {16'h0, v, 6'h0});
        rc(arc_pkg::OFS_RESULT8, {24'h0, v[9:2]});
    endtask : t_conv
    task automatic t_first;
        int n;
        rc(arc_pkg::OFS_RESULT10, 32'h0);
        rc(arc_pkg::OFS_RESULT8, 32'h0);
        rc(arc_pkg::OFS_IRQ_STAT, 32'h0);
        rc(8'h40, 32'h0);
        vin <= 10'h2a5;
        wr(arc_pkg::OFS_IRQ_EN, 32'h1);
        wr(arc_pkg::OFS_CHSEL, 32'h3);
        wr(arc_pkg::OFS_MODE, RUN);
        // start beside enable: this first result is stored but not checked
        wait_irq(n);
        check(n >= CONV + 1 && n <= CONV + 5, 1'b1);
        check(cen, 1'b1);
    endtask : t_first
    task automatic t_read_race;
        logic [31:0] old;
        logic [31:0] v;
        logic        ok;
        logic        got;
        ok  = 1'b1;
        got = 1'b0;
        rd(arc_pkg::OFS_RESULT10, old);
        wr(arc_pkg::OFS_IRQ_CLEAR, 32'h1);
        // change the input only while sampling, so no mixed result
        wait_so(1'b0);
        wait_so(1'b1);
        vin <= 10'h0f0;
        put(arc_pkg::OFS_RESULT10, 1'b0);
        // reads every cycle so one must meet the store
        repeat (3 * CONV) begin
            tick();
            v   = hrdata;
            got = got || (v === 32'h3c00);
            ok  = ok && (v === 32'h3c00 || (!got && v === old));
        end
        htrans <= 2'b00;
        tick();
        check(ok && got, 1'b1);
    endtask : t_read_race
    task automatic t_chsel;
        wait_so(1'b1);
        wait_so(1'b0);
        // channel write while converting must keep the end flag; port config write follows
        wr(arc_pkg::OFS_CHSEL, 32'h5);
        #1;
        check(irq, 1'b1);
        rc(arc_pkg::OFS_IRQ_STAT, 32'h1);
        check(ch, 3'h5);
        wr(arc_pkg::OFS_PORTCFG, 32'ha);
        #1;
        check(pcfg, 4'ha);
    endtask : t_chsel
    task automatic t_cfg_race;
        logic [7:0]  a [3];
        logic [31:0] d [3];
        logic [31:0] old;
        int          n;
        a = '{arc_pkg::OFS_PORTCFG, arc_pkg::OFS_MODE, arc_pkg::OFS_CHSEL};
        d = '{32'ha, RUN, 32'h5};
        wait_so(1'b0);
        wait_so(1'b1);
        wr(arc_pkg::OFS_IRQ_CLEAR, 32'h1);
        rd(arc_pkg::OFS_RESULT10, old);
        vin <= 10'h333;
        // a config data phase in every cycle meets each end
        for (int i = 0; i < 3 * CONV; i++) begin
            if (i > 0) hwdata <= d[(i - 1) % 3];
            put(a[i % 3], 1'b1);
        end
        htrans <= 2'b00;
        hwdata <= d[(3 * CONV - 1) % 3];
        tick();
        check(irq, 1'b0);
        rc(arc_pkg::OFS_RESULT10, old);
        wait_irq(n);
        rc(arc_pkg::OFS_RESULT10, 32'hccc0);
    endtask : t_cfg_race
    task automatic t_mask;
        wr(arc_pkg::OFS_IRQ_EN, 32'h0);
        wr(arc_pkg::OFS_IRQ_CLEAR, 32'h1);
        repeat (CONV + 4) @(posedge core_clk);
        check(irq, 1'b0);
        rc(arc_pkg::OFS_IRQ_STAT, 32'h1);
        wait_so(1'b0);
        wait_so(1'b1);
        wr(arc_pkg::OFS_IRQ_EN, 32'h1);
        tick();
        check(irq, 1'b1);
        wr(arc_pkg::OFS_IRQ_CLEAR, 32'h1);
        tick();
        check(irq, 1'b0);
    endtask : t_mask
    task automatic t_stop;
        logic [31:0] old;
        int          n;
        rd(arc_pkg::OFS_RESULT10, old);
        wr(arc_pkg::OFS_MODE, 32'h03);
        wr(arc_pkg::OFS_IRQ_CLEAR, 32'h1);
        repeat (2 * CONV) @(posedge core_clk);
        check(conv_busy | irq, 1'b0);
        rc(arc_pkg::OFS_RESULT10, old);
        stop_mode <= 1'b1;
        wr(arc_pkg::OFS_IRQ_CLEAR, 32'h1);
        wr(arc_pkg::OFS_MODE, RUN);
        repeat (2 * CONV) @(posedge core_clk);
        check(irq, 1'b0);
        stop_mode <= 1'b0;
        wait_irq(n);
        check(irq, 1'b1);
        wr(arc_pkg::OFS_MODE, 32'h00);
        #1;
        check(cen, 1'b0);
    endtask : t_stop
    task automatic t_reset;
        rst_n <= 1'b0;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rc(arc_pkg::OFS_RESULT10, 32'h0);
        rc(arc_pkg::OFS_RESULT8, 32'h0);
    endtask : t_reset
    task automatic final_report;
        if (failures == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report
    initial begin
        #40000;
        failures++;
        final_report();
    end
    initial begin
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        t_first();
        t_conv(10'h15a);
        t_read_race();
        t_chsel();
        t_cfg_race();
        t_mask();
        t_stop();
        t_reset();
        final_report();
    end
endmodule : testbench
